// ---- verilog/mdsd_top.sv ----
// Functional notes
// RL1: One 17x17 single-cycle multiplier shared by ALU and DSP operations.
// RL2: Multiplier handles signed, unsigned and mixed-sign operands per operation.
// RL3: 16-bit operands extended to 17 bits so unsigned and mixed-sign products are exact; fractional 0x8000 x 0x8000 wraps to 0x80000000.
// RL4: Divider does 16/16 and 32/16, integer and fractional.
// RL5: Division advances one step per cycle; sequencer repeats it, 19 steps total.
// RL6: Division can be suspended at any step and resumes without loss.
// RL7: 40-bit barrel shifter shifts left or right up to 16 in one cycle.
// RL8: Shifter shared by ALU and DSP, input chosen by instruction class.
// RL9: Signed count sets direction; zero fill, sign fill for arithmetic right.
`default_nettype none
module mdsd_top (
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        mul_en_i,
    input  wire logic        mul_src_i,
    input  wire logic [1:0]  mul_mode_i,
    input  wire logic        mul_frac_i,
    input  wire logic [15:0] mul_alu_a_i,
    input  wire logic [15:0] mul_alu_b_i,
    input  wire logic [15:0] mul_dsp_a_i,
    input  wire logic [15:0] mul_dsp_b_i,
    output logic      [31:0] mul_prod_o,
    output logic             mul_vld_o,
    input  wire logic        sh_en_i,
    input  wire logic        sh_src_i,
    input  wire logic        sh_arith_i,
    input  wire logic [5:0]  sh_cnt_i,
    input  wire logic [15:0] sh_alu_in_i,
    input  wire logic [39:0] sh_dsp_in_i,
    output logic      [39:0] sh_out_o,
    output logic             sh_vld_o,
    input  wire logic        div_step_i,
    input  wire logic        div_long_i,
    input  wire logic        div_frac_i,
    input  wire logic        div_sgn_i,
    input  wire logic [31:0] div_dividend_i,
    input  wire logic [15:0] div_divisor_i,
    output logic      [15:0] div_quot_o,
    output logic      [15:0] div_rem_o,
    output logic             div_busy_o,
    output logic             div_done_o
);
    typedef struct packed {
        logic [31:0] prod;
        logic        mvld;
        logic [39:0] sh;
        logic        svld;
    } mdsd_st_t;

    mdsd_st_t    st_ff;
    mdsd_st_t    nxt_st;
    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    logic [15:0] ma;
    logic [15:0] mb;
    logic [16:0] ea;
    logic [16:0] eb;
    logic [33:0] prod_full;
    logic [39:0] sh_in;
    logic [4:0]  sh_amt;
    logic        sh_left;
    logic [39:0] sh_res;
    mdsd_div_if  div_bus ();

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ----------------------------------------------------------------
    // Operand extension helper
    // ----------------------------------------------------------------
    function automatic logic [16:0] mdsd_ext(input logic [15:0] v, input logic sgn);
        return {sgn & v[15], v};
    endfunction

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // One multiplier, operands picked by issuing class
        ma = (mul_src_i == mdsd_pkg::MDSD_SRC_DSP) ? mul_dsp_a_i : mul_alu_a_i; //RL1
        mb = (mul_src_i == mdsd_pkg::MDSD_SRC_DSP) ? mul_dsp_b_i : mul_alu_b_i;
        // Mixed mode: first operand signed, second unsigned
        ea = mdsd_ext(ma, mul_mode_i != 2'(mdsd_pkg::MDSD_MUL_UU)); //RL2
        eb = mdsd_ext(mb, mul_mode_i == 2'(mdsd_pkg::MDSD_MUL_SS));
        // 17-bit signed product of extended operands is always exact
        prod_full = 34'($signed(ea) * $signed(eb)); //RL3
        nxt_st.mvld = mul_en_i;
        if (mul_en_i) begin
            nxt_st.prod = mul_frac_i ? {prod_full[30:0], 1'b0} : prod_full[31:0];
        end

        // ALU value enters low 16 bits, extended only for arithmetic shifts
        if (sh_src_i == mdsd_pkg::MDSD_SRC_DSP) begin //RL8
            sh_in = sh_dsp_in_i;
        end else begin
            sh_in = {{24{sh_arith_i & sh_alu_in_i[15]}}, sh_alu_in_i};
        end
        // Positive count shifts left; magnitude clamps at 16
        sh_left = !sh_cnt_i[5]; //RL9
        sh_amt  = sh_left ? (sh_cnt_i[4:0] > 5'h10 ? 5'h10 : sh_cnt_i[4:0])
                          : (sh_cnt_i < 6'h30 ? 5'h10 : 5'(6'(-sh_cnt_i)));
        if (sh_left) begin //RL7
            sh_res = sh_in << sh_amt;
        end else if (sh_arith_i) begin
            sh_res = 40'($signed(sh_in) >>> sh_amt);
        end else begin
            sh_res = sh_in >> sh_amt;
        end
        nxt_st.svld = sh_en_i;
        if (sh_en_i) begin
            nxt_st.sh = sh_res;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    assign div_bus.step     = div_step_i; //RL5
    assign div_bus.long_op  = div_long_i;
    assign div_bus.frac     = div_frac_i;
    assign div_bus.sgn      = div_sgn_i;
    assign div_bus.dividend = div_dividend_i;
    assign div_bus.divisor  = div_divisor_i;

    mdsd_div u_div (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n),
        .d_if       (div_bus)
    );

    assign mul_prod_o = st_ff.prod;
    assign mul_vld_o  = st_ff.mvld;
    assign sh_out_o   = st_ff.sh;
    assign sh_vld_o   = st_ff.svld;
    assign div_quot_o = div_bus.quot;
    assign div_rem_o  = div_bus.rem;
    assign div_busy_o = div_bus.busy;
    assign div_done_o = div_bus.done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    mul_latency_a: assert property (mul_en_i |=> mul_vld_o)
        else $error("product not valid one cycle after request"); //RL1
    mul_signed_a: assert property (mul_en_i && !mul_frac_i
        && mul_mode_i == 2'h0 |=> mul_prod_o ==
        32'($signed($past(ma)) * $signed($past(mb))))
        else $error("signed product wrong"); //RL2
    mul_unsigned_a: assert property (mul_en_i && !mul_frac_i
        && mul_mode_i == 2'h1 |=> mul_prod_o == 32'($past(ma)) * 32'($past(mb)))
        else $error("unsigned product wrong"); //RL2
    mul_minus_one_a: assert property (mul_en_i && mul_frac_i && mul_mode_i == 2'h0
        && ma == 16'h8000 && mb == 16'h7FFF |=> mul_prod_o == 32'h80010000)
        else $error("fractional corner product wrong"); //RL3
    sh_zero_fill_a: assert property (sh_en_i && !sh_arith_i && sh_cnt_i == 6'h30
        |=> sh_out_o[39:24] == 16'h0000) else $error("logical right shift not zero filled"); //RL9
    sh_left_a: assert property (sh_en_i && sh_cnt_i == 6'h10
        |=> sh_out_o[15:0] == 16'h0000 && sh_vld_o)
        else $error("left shift by 16 wrong"); //RL7
    sh_src_a: assert property (sh_en_i && sh_src_i && sh_cnt_i == 6'h00
        |=> sh_out_o == $past(sh_dsp_in_i)) else $error("shifter input select wrong"); //RL8
    // Mixed and mode 3 share one decode: first operand signed only
    mul_mixed_a: assert property (mul_en_i && !mul_frac_i && mul_mode_i[1]
        |=> mul_prod_o == 32'($signed({$past(ma[15]), $past(ma)})
        * $signed({1'b0, $past(mb)})))
        else $error("mixed sign product wrong"); //RL2
    // Valid strobes are one-cycle pulses, results hold until next request
    mul_vld_pulse_a: assert property (!mul_en_i |=> !mul_vld_o)
        else $error("product valid without request"); //RL1
    mul_hold_a: assert property (!mul_en_i |=> $stable(mul_prod_o))
        else $error("product changed without request"); //RL1
    sh_vld_pulse_a: assert property (!sh_en_i |=> !sh_vld_o)
        else $error("shift valid without request"); //RL7
    sh_hold_a: assert property (!sh_en_i |=> $stable(sh_out_o))
        else $error("shift result changed without request"); //RL7
    sh_sign_fill_a: assert property (sh_en_i && sh_arith_i && sh_src_i && sh_cnt_i == 6'h30
        |=> sh_out_o[39:24] == {16{$past(sh_dsp_in_i[39])}})
        else $error("arithmetic right shift not sign filled"); //RL9
    sh_clamp_c: cover property (sh_en_i && sh_cnt_i == 6'h20);
    mul_dsp_c: cover property (mul_en_i && mul_src_i && mul_mode_i == 2'h2);
    sh_arith_c: cover property (sh_en_i && sh_arith_i && sh_cnt_i[5]);
endmodule
`default_nettype wire

// ---- verilog/mdsd_pkg.sv ----
`default_nettype none
package mdsd_pkg;
    localparam int unsigned MUL_W     = 16;
    localparam int unsigned MUL_EXT_W = 17;
    localparam int unsigned PROD_W    = 32;
    localparam int unsigned SH_W      = 40;
    localparam int unsigned SH_CNT_W  = 6;
    localparam int unsigned SH_MAX    = 16;
    localparam int unsigned DIV_W     = 16;
    localparam int unsigned DVD_W     = 32;
    localparam int unsigned DIV_STEPS = 19;
    localparam int unsigned DIV_CNT_W = 5;
    localparam logic [4:0]  DIV_ITER_LAST = 5'h10;
    localparam logic [4:0]  DIV_FIX_STEP  = 5'h11;
    localparam logic [4:0]  DIV_LAST_STEP = 5'h12;
    localparam int unsigned FRAC_SHORT_SH = 15;

    typedef enum logic [1:0] {
        MDSD_MUL_SS,
        MDSD_MUL_UU,
        MDSD_MUL_SU
    } mdsd_mul_mode_t;

    typedef enum logic {
        MDSD_SRC_ALU,
        MDSD_SRC_DSP
    } mdsd_src_t;
endpackage
`default_nettype wire

// ---- verilog/mdsd_div_if.sv ----
`default_nettype none
interface mdsd_div_if;
    logic        step;
    logic        long_op;
    logic        frac;
    logic        sgn;
    logic [31:0] dividend;
    logic [15:0] divisor;
    logic [15:0] quot;
    logic [15:0] rem;
    logic        busy;
    logic        done;

    modport ctl (output step, long_op, frac, sgn, dividend, divisor,
                 input  quot, rem, busy, done);
    modport div (input  step, long_op, frac, sgn, dividend, divisor,
                 output quot, rem, busy, done);
endinterface
`default_nettype wire

// ---- verilog/mdsd_div.sv ----
`default_nettype none
module mdsd_div (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    mdsd_div_if.div   d_if
);
    typedef struct packed {
        logic [4:0]  cnt;
        logic [16:0] r;
        logic [15:0] q;
        logic [15:0] den;
        logic        negq;
        logic        negr;
        logic        busy;
        logic        done;
    } mdsd_div_st_t;

    mdsd_div_st_t st_ff;
    mdsd_div_st_t nxt_st;
    logic [31:0]  eff;
    logic [31:0]  mag;
    logic [16:0]  trial;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        // Operand forms for 16/16 and 32/16, integer and fractional
        if (d_if.long_op) begin //RL4
            eff = d_if.frac ? {d_if.dividend[31], d_if.dividend[31:1]} : d_if.dividend;
        end else if (d_if.frac) begin
            eff = 32'({{16{d_if.dividend[15]}}, d_if.dividend[15:0]}
                  << mdsd_pkg::FRAC_SHORT_SH);
        end else begin
            eff = {{16{d_if.sgn & d_if.dividend[15]}}, d_if.dividend[15:0]};
        end
        mag   = (d_if.sgn && eff[31]) ? 32'(-eff) : eff;
        trial = {st_ff.r[15:0], st_ff.q[15]};
        // Only the done pulse clears without a step, so an interrupt loses nothing
        if (d_if.step) begin //RL6
            if (!st_ff.busy) begin //RL5
                nxt_st.cnt  = 5'h01;
                nxt_st.busy = 1'b1;
                nxt_st.r    = {1'b0, mag[31:16]};
                nxt_st.q    = mag[15:0];
                nxt_st.den  = (d_if.sgn && d_if.divisor[15]) ? 16'(-d_if.divisor)
                                                             : d_if.divisor;
                nxt_st.negq = d_if.sgn & (eff[31] ^ d_if.divisor[15]);
                nxt_st.negr = d_if.sgn & eff[31];
            end else begin
                nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
                if (st_ff.cnt <= mdsd_pkg::DIV_ITER_LAST) begin
                    if (trial >= {1'b0, st_ff.den}) begin
                        nxt_st.r = 17'(trial - {1'b0, st_ff.den});
                        nxt_st.q = {st_ff.q[14:0], 1'b1};
                    end else begin
                        nxt_st.r = trial;
                        nxt_st.q = {st_ff.q[14:0], 1'b0};
                    end
                end else if (st_ff.cnt == mdsd_pkg::DIV_FIX_STEP) begin
                    if (st_ff.negq) begin
                        nxt_st.q = 16'(-st_ff.q);
                    end
                    if (st_ff.negr) begin
                        nxt_st.r = {1'b0, 16'(-st_ff.r[15:0])};
                    end
                end else begin
                    nxt_st.cnt  = 5'h00;
                    nxt_st.busy = 1'b0;
                    nxt_st.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign d_if.quot = st_ff.q;
    assign d_if.rem  = st_ff.r[15:0];
    assign d_if.busy = st_ff.busy;
    assign d_if.done = st_ff.done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    div_last_step_a: assert property (d_if.step && st_ff.busy && st_ff.cnt == 5'h12
        |=> d_if.done && !d_if.busy) else $error("divide did not end on step 19"); //RL5
    div_early_done_a: assert property (d_if.done |-> $past(st_ff.cnt) == 5'h12)
        else $error("divide ended early"); //RL5
    div_hold_a: assert property (!d_if.step |=> $stable(st_ff.cnt) && $stable(st_ff.r)
        && $stable(st_ff.q)) else $error("divide state moved while suspended"); //RL6
    div_start_a: assert property (d_if.step && !st_ff.busy |=> st_ff.cnt == 5'h01
        && d_if.busy) else $error("divide load failed"); //RL4
    div_full_c: cover property (d_if.step ##1 !d_if.step && st_ff.busy ##1 d_if.step);
    div_done_c: cover property (d_if.done);
endmodule
`default_nettype wire

// ---- bench/mdsd_seq_model.sv ----
`default_nettype none
module mdsd_seq_model (
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic go_i,
    input  wire logic slow_i,
    output logic      step_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Repeat loop of divide steps
    // ------------------------------------------------------------
    logic [4:0] cnt_ff;
    logic       ph_ff;
    // Slow mode stalls every other cycle, as an interrupt would
    assign step_o = (cnt_ff != 5'h00) && !(slow_i && ph_ff);
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= 5'h00;
            ph_ff  <= 1'b0;
        end else begin
            ph_ff <= ~ph_ff;
            if (go_i) begin
                cnt_ff <= 5'h13;
            end else if (step_o) begin
                cnt_ff <= cnt_ff - 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/multiply_divide_shift_datapath_test.sv ----
`default_nettype none
module multiply_divide_shift_datapath_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------------------
    logic        clk = 1'b0, rstn = 1'b0;
    logic        mul_en = 0, mul_src = 0, mul_frac = 0;
    logic [1:0]  mul_mode = 0;
    logic [15:0] ma = 0, mb = 0, da = 0, db = 0;
    logic [31:0] prod;
    logic        mul_vld, sh_en = 0, sh_src = 0, sh_arith = 0;
    logic [5:0]  sh_cnt = 0;
    logic [15:0] sh_alu = 0;
    logic [39:0] sh_dsp = 0, sh_out;
    logic        sh_vld, div_step, dlong = 0, dfrac = 0, dsgn = 0;
    logic [31:0] dvd = 0;
    logic [15:0] dvs = 0, quot, rem;
    logic        busy, done, go = 0, slow = 0;
    int          failures = 0, tests_run = 0;
    always #4 clk = ~clk;
    mdsd_seq_model seq (.core_clk_i(clk), .rstn_i(rstn), .go_i(go), .slow_i(slow),
                        .step_o(div_step));
    mdsd_top dut (.core_clk_i(clk), .rstn_i(rstn), .mul_en_i(mul_en), .mul_src_i(mul_src),
        .mul_mode_i(mul_mode), .mul_frac_i(mul_frac), .mul_alu_a_i(ma), .mul_alu_b_i(mb),
        .mul_dsp_a_i(da), .mul_dsp_b_i(db), .mul_prod_o(prod), .mul_vld_o(mul_vld),
        .sh_en_i(sh_en), .sh_src_i(sh_src), .sh_arith_i(sh_arith), .sh_cnt_i(sh_cnt),
        .sh_alu_in_i(sh_alu), .sh_dsp_in_i(sh_dsp), .sh_out_o(sh_out), .sh_vld_o(sh_vld),
        .div_step_i(div_step), .div_long_i(dlong), .div_frac_i(dfrac), .div_sgn_i(dsgn),
        .div_dividend_i(dvd), .div_divisor_i(dvs), .div_quot_o(quot), .div_rem_o(rem),
        .div_busy_o(busy), .div_done_o(done));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            failures++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    // Unused source gets inverted operands so a wrong select shows
    task automatic mul_t(input logic s, input logic [1:0] md, input logic f,
                         input logic [15:0] a, input logic [15:0] b, input logic [31:0] e);
        @(posedge clk) #1;
        {mul_en, mul_src, mul_mode, mul_frac} = {1'b1, s, md, f};
        {ma, mb, da, db} = s ? {~a, ~b, a, b} : {a, b, ~a, ~b};
        @(posedge clk) #1;
        mul_en = 0;
        chk(mul_vld === 1'b1 && prod === e, "product");
        @(posedge clk) #1;
        chk(mul_vld === 1'b0 && prod === e, "product pulse or hold");
    endtask
    task automatic sh_t(input logic s, input logic ar, input logic [5:0] c,
                        input logic [39:0] din, input logic [39:0] e);
        @(posedge clk) #1;
        {sh_en, sh_src, sh_arith, sh_cnt} = {1'b1, s, ar, c};
        sh_alu = s ? ~din[15:0] : din[15:0];
        sh_dsp = s ? din : ~din;
        @(posedge clk) #1;
        sh_en = 0;
        chk(sh_vld === 1'b1 && sh_out === e, "shift result");
        @(posedge clk) #1;
        chk(sh_vld === 1'b0 && sh_out === e, "shift pulse or hold");
    endtask
    task automatic div_t(input logic l, input logic f, input logic sg, input logic sl,
                         input logic [31:0] x, input logic [15:0] y,
                         input logic [15:0] eq, input logic [15:0] er);
        int n;
        int i;
        n = 0;
        @(posedge clk) #1;
        {dlong, dfrac, dsgn, slow, dvd, dvs, go} = {l, f, sg, sl, x, y, 1'b1};
        @(posedge clk) #1;
        go = 0;
        for (i = 0; i < 100 && done !== 1'b1; i++) begin
            @(posedge clk);
            if (div_step === 1'b1) n++;
            if (n == 10) chk(busy === 1'b1, "busy mid division");
            #1;
        end
        if (i == 100) begin
            failures++;
            $display("ERROR %0t divide timed out", $time);
            finish_test();
        end
        chk(n == 19, "step count");
        chk(quot === eq && rem === er, "quotient or remainder");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_mul();
        mul_t(0, 2'h0, 0, 16'hFFFF, 16'h0001, 32'hFFFFFFFF);
        mul_t(1, 2'h1, 0, 16'hFFFF, 16'hFFFF, 32'hFFFE0001);
        mul_t(0, 2'h2, 0, 16'hFFFF, 16'hFFFF, 32'hFFFF0001);
        mul_t(1, 2'h3, 0, 16'hFFFF, 16'hFFFF, 32'hFFFF0001);
        mul_t(1, 2'h0, 1, 16'h8000, 16'h7FFF, 32'h80010000);
        mul_t(0, 2'h0, 1, 16'h8000, 16'h8000, 32'h80000000);
        $display("test mul end");
    endtask
    task automatic test_shift();
        sh_t(0, 1, 6'h3C, 40'h0000008000, 40'hFFFFFFF800);
        sh_t(0, 0, 6'h10, 40'h000000ABCD, 40'h00ABCD0000);
        sh_t(1, 0, 6'h30, 40'hFF00000000, 40'h0000FF0000);
        sh_t(1, 1, 6'h20, 40'h8000000000, 40'hFFFF800000);
        sh_t(1, 0, 6'h01, 40'h8000000001, 40'h0000000002);
        sh_t(1, 0, 6'h00, 40'h123456789A, 40'h123456789A);
        $display("test shift end");
    endtask
    task automatic test_div();
        div_t(0, 0, 0, 0, 32'h00000064, 16'h0007, 16'h000E, 16'h0002);
        div_t(1, 0, 1, 1, 32'hFFFE7960, 16'h0007, 16'hC833, 16'hFFFB);
        div_t(0, 0, 1, 0, 32'h0000FF9C, 16'h0007, 16'hFFF2, 16'hFFFE);
        div_t(0, 1, 1, 1, 32'h00002000, 16'h4000, 16'h4000, 16'h0000);
        div_t(1, 1, 1, 0, 32'h20000000, 16'h4000, 16'h4000, 16'h0000);
        div_t(1, 0, 0, 1, 32'h00012345, 16'h0100, 16'h0123, 16'h0045);
        $display("test div end");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        test_mul();
        test_shift();
        test_div();
        finish_test();
    end
endmodule
`default_nettype wire
